// ---- rtl/psecm_top.v ----
// Channel mode control with its two-wire register port, four channels.
`timescale 1ns/10ps
`include "psecm_defs.vh"

module psecm_top (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output reg        sda_oe,
  input  wire [3:0] address_strap_pin,
  input  wire       group_pin,
  input  wire       config_b,
  input  wire [3:0] det_done,
  input  wire [3:0] det_valid,
  input  wire [3:0] cls_done,
  input  wire [3:0] pg_in,
  input  wire [3:0] alloc_ok,
  input  wire [3:0] cooldown,
  input  wire [3:0] trip_off,
  output reg  [3:0] det_start,
  output reg  [3:0] cls_start,
  output reg  [3:0] power_enable,
  output reg  [3:0] off_clear,
  output reg  [3:0] cool_cancel,
  output reg  [3:0] manual_power
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Straps pass the same three stages; a strap change is followed live.
  localparam SW = 8;
  reg  [SW-1:0] s1;
  reg  [SW-1:0] s2;
  reg  [SW-1:0] s3;
  reg  [SW-1:0] filt;
  wire [SW-1:0] pins = {config_b, group_pin, address_strap_pin, sda_i, scl_i};

  always @(posedge mclk) begin
    if (!rst_b) begin
      s1   <= {SW{1'b1}};
      s2   <= {SW{1'b1}};
      s3   <= {SW{1'b1}};
      filt <= {SW{1'b1}};
    end else begin
      s1   <= pins;
      s2   <= s1;
      s3   <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end

  wire       scl = filt[0];
  wire       sda = filt[1];
  wire [3:0] strap_address_bits = filt[5:2];
  // Group bit forced low in B
  wire       group_select_address_bit = filt[6] & ~filt[7];

  reg scl_d;
  reg sda_d;
  always @(posedge mclk) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire i2c_start = scl & scl_d & sda_d & ~sda;
  wire i2c_stop  = scl & scl_d & ~sda_d & sda;

  // ************************************************************
  // Two-wire slave
  // ************************************************************
  localparam [4:0] B_IDLE = 5'h01;
  localparam [4:0] B_RX   = 5'h02;
  localparam [4:0] B_ACK  = 5'h04;
  localparam [4:0] B_TX   = 5'h08;
  localparam [4:0] B_MACK = 5'h10;

  reg [4:0] bst;
  reg [7:0] sh;
  reg [3:0] bcnt;
  reg [1:0] bidx;
  reg       rw;
  reg [7:0] ptr;
  reg       wr_stb;
  reg [7:0] wr_data;
  reg       evt_rd;
  reg [7:0] rd_val;

  wire addr_hit = (sh[7:1] == {`PSECM_ADDR_PREFIX, strap_address_bits,
                               group_select_address_bit}) ||
                  (sh[7:1] == `PSECM_ADDR_BCAST);

  assign sda_o = 1'b0;

  always @(posedge mclk) begin
    if (!rst_b) begin
      bst     <= B_IDLE;
      sh      <= 8'h00;
      bcnt    <= 4'h0;
      bidx    <= 2'h0;
      rw      <= 1'b0;
      ptr     <= 8'h00;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
      evt_rd  <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      evt_rd <= 1'b0;
      if (i2c_start) begin
        bst    <= B_RX;
        bcnt   <= 4'h0;
        bidx   <= 2'h0;
        sda_oe <= 1'b0;
      end else if (i2c_stop) begin
        bst    <= B_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (bst)
          B_IDLE: begin
            sda_oe <= 1'b0;
          end
          B_RX: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda};
              bcnt <= bcnt + 4'h1;
            end else if (scl_fall && bcnt == 4'h8) begin
              if (bidx == 2'h0) begin
                if (addr_hit) begin
                  rw     <= sh[0];
                  sda_oe <= 1'b1;
                  bst    <= B_ACK;
                end else begin
                  bst <= B_IDLE;
                end
              end else begin
                if (bidx == 2'h1) begin
                  ptr <= sh;
                end else begin
                  wr_stb  <= 1'b1;
                  wr_data <= sh;
                end
                sda_oe <= 1'b1;
                bst    <= B_ACK;
              end
            end
          end
          B_ACK: begin
            if (scl_fall) begin
              bcnt <= 4'h0;
              if (rw && bidx == 2'h0) begin
                sh     <= rd_val;
                sda_oe <= ~rd_val[7];
                evt_rd <= (ptr == `PSECM_CMD_PWR_EVENT);
                bst    <= B_TX;
              end else begin
                sda_oe <= 1'b0;
                bidx   <= (bidx == 2'h2) ? 2'h2 : bidx + 2'h1;
                bst    <= B_RX;
              end
            end
          end
          B_TX: begin
            if (scl_rise) begin
              bcnt <= bcnt + 4'h1;
            end else if (scl_fall) begin
              if (bcnt == 4'h8) begin
                sda_oe <= 1'b0;
                bst    <= B_MACK;
              end else begin
                sh     <= {sh[6:0], 1'b0};
                sda_oe <= ~sh[6];
              end
            end
          end
          B_MACK: begin
            if (scl_rise && sda) begin
              bst <= B_IDLE;
            end else if (scl_fall) begin
              bcnt   <= 4'h0;
              sh     <= rd_val;
              sda_oe <= ~rd_val[7];
              evt_rd <= (ptr == `PSECM_CMD_PWR_EVENT);
              bst    <= B_TX;
            end
          end
          default: begin
            bst    <= B_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [7:0] channel_mode_select;
  wire [7:0] det_cls_en;
  wire [7:0] pwr_event;
  wire [7:0] pwr_status;

  always @(posedge mclk) begin
    if (!rst_b) begin
      channel_mode_select <= `PSECM_MODE_RST;
    end else if (wr_stb && ptr == `PSECM_CMD_MODE) begin
      channel_mode_select <= wr_data;
    end
  end

  // Reserved bits zero, no write path
  wire [7:0] strap_address_readback = {1'b0, strap_address_bits,
                                       group_select_address_bit, 2'b00};

  always @* begin
    case (ptr)
      `PSECM_CMD_PWR_EVENT:  rd_val = pwr_event;
      `PSECM_CMD_PWR_STATUS: rd_val = pwr_status;
      `PSECM_CMD_ADDR_RB:    rd_val = strap_address_readback;
      `PSECM_CMD_MODE:       rd_val = channel_mode_select;
      `PSECM_CMD_DET_CLS_EN: rd_val = det_cls_en;
      default:               rd_val = 8'h00;
    endcase
  end

  wire wr_dce = wr_stb && (ptr == `PSECM_CMD_DET_CLS_EN);
  wire wr_pon = wr_stb && (ptr == `PSECM_CMD_PWR_ON);

  // ************************************************************
  // Per-channel sequencers
  // ************************************************************
  localparam [3:0] C_IDLE = 4'h1;
  localparam [3:0] C_DET  = 4'h2;
  localparam [3:0] C_CLS  = 4'h4;
  localparam [3:0] C_ON   = 4'h8;

  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_ch
      wire [1:0] mode = channel_mode_select[2*n+1:2*n];
      reg  [1:0] mode_prev;
      reg  [3:0] cst;
      reg        det_en;
      reg        cls_en;
      reg        pg;
      reg        pgc;
      reg        pec;
      wire is_off  = (mode == `PSECM_MODE_OFF);
      wire is_man  = (mode == `PSECM_MODE_MANUAL);
      wire is_semi = (mode == `PSECM_MODE_SEMI);
      wire is_auto = (mode == `PSECM_MODE_AUTO);
      wire off_entry = is_off && (mode_prev != `PSECM_MODE_OFF);
      wire pon_req = wr_pon && wr_data[n];
      wire pe = power_enable[n];
      // The enable strobe from software wins over the sequencer's own clear.
      wire det_wr = wr_dce ? wr_data[n] : det_en;
      wire cls_wr = wr_dce ? wr_data[`PSECM_CLS_EN_LSB+n] : cls_en;
      wire pe_fall = pe && (is_off || trip_off[n]);

      assign det_cls_en[n] = det_en;
      assign det_cls_en[`PSECM_CLS_EN_LSB+n] = cls_en;
      assign pwr_status[n] = pe;
      assign pwr_status[`PSECM_PG_LSB+n] = pg;
      assign pwr_event[n] = pec;
      assign pwr_event[`PSECM_PG_LSB+n] = pgc;

      always @(posedge mclk) begin
        if (!rst_b) begin
          mode_prev       <= `PSECM_MODE_OFF;
          cst             <= C_IDLE;
          det_en          <= 1'b0;
          cls_en          <= 1'b0;
          pg              <= 1'b0;
          pgc             <= 1'b0;
          pec             <= 1'b0;
          power_enable[n] <= 1'b0;
          det_start[n]    <= 1'b0;
          cls_start[n]    <= 1'b0;
          off_clear[n]    <= 1'b0;
          cool_cancel[n]  <= 1'b0;
          manual_power[n] <= 1'b0;
        end else begin
          mode_prev    <= mode;
          det_start[n] <= 1'b0;
          cls_start[n] <= 1'b0;
          det_en       <= det_wr;
          cls_en       <= cls_wr;
          // Clear strobe to event, fault and measurement owners
          // Same strobe presets policing, clears autoclass and fault
          // Same strobe clears measurements and classes
          // Done in one cycle, far inside 5 ms
          off_clear[n] <= off_entry;
          cool_cancel[n] <= (mode_prev == `PSECM_MODE_SEMI) && (is_man || is_off);
          // Falling status sets change events, set beats read clear
          pec <= pe_fall | (pec & ~evt_rd);
          pgc <= (pg && pe_fall) | (pgc & ~evt_rd);
          if (pe && pg_in[n] && !pe_fall) begin
            pg <= 1'b1;
          end
          if (is_off) begin
            // Off mode holds the channel idle and unpowered
            // Clear enables and power status on entry
            cst             <= C_IDLE;
            power_enable[n] <= 1'b0;
            pg              <= 1'b0;
            manual_power[n] <= 1'b0;
            if (off_entry) begin
              det_en <= 1'b0;
              cls_en <= 1'b0;
            end
          end else if (pon_req && !pe) begin
            // Flag that no class was assigned
            cst             <= C_ON;
            power_enable[n] <= 1'b1;
            manual_power[n] <= is_man;
          end else begin
            case (cst)
              C_IDLE: begin
                if (!cooldown[n] && det_en &&
                    (is_man || is_semi || (is_auto && cls_en))) begin
                  cst          <= C_DET;
                  det_start[n] <= 1'b1;
                end else if (!cooldown[n] && is_man && cls_en) begin
                  cst          <= C_CLS;
                  cls_start[n] <= 1'b1;
                end
              end
              C_DET: begin
                if (det_done[n]) begin
                  if (is_man) begin
                    det_en <= wr_dce & wr_data[n];
                  end
                  if (cls_en && (is_man || det_valid[n])) begin
                    cst          <= C_CLS;
                    cls_start[n] <= 1'b1;
                  end else begin
                    // Semiauto goes round again from idle
                    cst <= C_IDLE;
                  end
                end
              end
              C_CLS: begin
                if (cls_done[n]) begin
                  if (is_man) begin
                    cls_en <= wr_dce & wr_data[`PSECM_CLS_EN_LSB+n];
                  end
                  // Auto powers on when allocation allows
                  if (is_auto && alloc_ok[n]) begin
                    cst             <= C_ON;
                    power_enable[n] <= 1'b1;
                  end else begin
                    cst <= C_IDLE;
                  end
                end
              end
              C_ON: begin
                if (trip_off[n]) begin
                  cst             <= C_IDLE;
                  power_enable[n] <= 1'b0;
                  pg              <= 1'b0;
                  manual_power[n] <= 1'b0;
                end
              end
              default: begin
                cst <= C_IDLE;
              end
            endcase
          end
        end
      end
    end
  endgenerate

endmodule

// ---- shared/psecm_defs.vh ----
// Constants for the channel mode control block.
`ifndef PSECM_DEFS_VH
`define PSECM_DEFS_VH
// ************************************************************
// Register commands
// ************************************************************
`define PSECM_CMD_PWR_EVENT   8'h02
`define PSECM_CMD_PWR_STATUS  8'h10
`define PSECM_CMD_ADDR_RB     8'h11
`define PSECM_CMD_MODE        8'h12
`define PSECM_CMD_DET_CLS_EN  8'h14
`define PSECM_CMD_PWR_ON      8'h19
// ************************************************************
// Reset values and fields
// ************************************************************
`define PSECM_MODE_RST        8'h00
`define PSECM_DCE_RST         8'h00
`define PSECM_CLS_EN_LSB      4
`define PSECM_PG_LSB          4
`define PSECM_STRAP_LSB       3
`define PSECM_GROUP_BIT       2
`define PSECM_ADDR_PREFIX     2'h1
`define PSECM_ADDR_BCAST      7'h7f
// ************************************************************
// Channel mode encoding
// ************************************************************
`define PSECM_MODE_OFF        2'h0
`define PSECM_MODE_MANUAL     2'h1
`define PSECM_MODE_SEMI       2'h2
`define PSECM_MODE_AUTO       2'h3
// ************************************************************
// Timing
// ************************************************************
`define PSECM_CLK_MHZ         40
`define PSECM_OFF_CLR_MS      5
`endif

// ---- tb/psecm_i2c_host.sv ----
// Two-wire host model that drives the register port of the mode control block.
`timescale 1ns/10ps
module psecm_i2c_host (
  input  wire  mclk,
  input  wire  sda_line,
  output logic scl_o,
  output logic sda_o
);
  // Each phase lasts eight cycles, which leaves margin over the slave's filter delay.
  localparam int HALF = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt();
    repeat (HALF) @(posedge mclk);
    #2;
  endtask
  // Data only moves while the clock is low, so no false start or stop is seen.
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    wt();
    scl_o = 1'b1;
    wt();
    s = sda_line;
    scl_o = 1'b0;
    wt();
  endtask
  task automatic start_c();
    sda_o = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    sda_o = 1'b0;
    wt();
    scl_o = 1'b0;
    wt();
  endtask
  task automatic stop_c();
    sda_o = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    sda_o = 1'b1;
    wt();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
      q[i] = s;
    end
    clk_bit(ab, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3;
    start_c();
    xfer({a, 1'b0}, 1'b1, q, k1);
    xfer(c, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop_c();
    ok = k1 & k2 & k3;
  endtask
  // A single data byte is read, closed by a not-acknowledge before the stop.
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] q,
                    output logic ok);
    logic k1, k2, k3, k4;
    start_c();
    xfer({a, 1'b0}, 1'b1, q, k1);
    xfer(c, 1'b1, q, k2);
    start_c();
    xfer({a, 1'b1}, 1'b1, q, k3);
    xfer(8'hff, 1'b1, q, k4);
    stop_c();
    ok = k1 & k2 & k3;
  endtask
endmodule

// ---- tb/psecm_props.sv ----
// Port-level assertions for the channel mode control block.
`timescale 1ns/10ps
module psecm_props (
  input wire       mclk,
  input wire       rst_b,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire [3:0] address_strap_pin,
  input wire       group_pin,
  input wire       config_b,
  input wire [3:0] det_done,
  input wire [3:0] det_valid,
  input wire [3:0] cls_done,
  input wire [3:0] pg_in,
  input wire [3:0] alloc_ok,
  input wire [3:0] cooldown,
  input wire [3:0] trip_off,
  input wire [3:0] det_start,
  input wire [3:0] cls_start,
  input wire [3:0] power_enable,
  input wire [3:0] off_clear,
  input wire [3:0] cool_cancel,
  input wire [3:0] manual_power
);
  // Remembers which channels went off last, so later checks look at them only.
  reg [3:0] off_mask;
  always @(posedge mclk) begin
    if (!rst_b) begin
      off_mask <= 4'h0;
    end else if (off_clear != 4'h0) begin
      off_mask <= off_clear;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_off_entry;
    off_clear != 4'h0;
  endsequence
  sequence s_off_quiet;
    (((det_start | cls_start | power_enable | manual_power) & off_mask) == 4'h0) [*4];
  endsequence
  a_off_quiet: assert property (s_off_entry |-> ##2 s_off_quiet)
    else $error("channel active after entering off mode");
  a_off_pulse: assert property (s_off_entry |=> (off_clear & off_mask) == 4'h0)
    else $error("off clear pulse longer than one cycle");
  a_cancel_pulse: assert property ((cool_cancel & $past(cool_cancel)) == 4'h0)
    else $error("cooldown cancel pulse longer than one cycle");
  a_det_single: assert property ((det_start & $past(det_start)) == 4'h0)
    else $error("detection start held two cycles");
  a_cls_single: assert property ((cls_start & $past(cls_start)) == 4'h0)
    else $error("classification start held two cycles");
  a_ack_timing: assert property ($rose(sda_oe) |-> !scl_i && !$past(scl_i, 3))
    else $error("data line pulled outside the clock low phase");
  a_oe_release: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("data line released while clock high");
  a_sda_low: assert property (sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> power_enable == 4'h0
    && off_clear == 4'h0 && det_start == 4'h0 && sda_oe == 1'b0)
    else $error("outputs active after reset");
endmodule
bind psecm_top psecm_props props_u (
  .mclk(mclk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .address_strap_pin(address_strap_pin), .group_pin(group_pin), .config_b(config_b),
  .det_done(det_done), .det_valid(det_valid), .cls_done(cls_done), .pg_in(pg_in),
  .alloc_ok(alloc_ok), .cooldown(cooldown), .trip_off(trip_off), .det_start(det_start),
  .cls_start(cls_start), .power_enable(power_enable), .off_clear(off_clear),
  .cool_cancel(cool_cancel), .manual_power(manual_power)
);

// ---- tb/testbench.sv ----
// Self-checking bench for the channel mode control block.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [7:0] cmd; logic [7:0] wd; logic [7:0] ex;} psecm_row_t;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cfg_b = 1'b0;
  logic [3:0] valid = 4'h0;
  logic [3:0] alloc = 4'h0;
  logic [3:0] cool = 4'h0;
  logic [3:0] trip = 4'h0;
  logic [3:0] det_done = 4'h0;
  logic [3:0] cls_done = 4'h0;
  logic [3:0] oc_seen = 4'h0;
  logic [3:0] cc_seen = 4'h0;
  logic [6:0] dev = 7'h35;
  logic [7:0] q;
  logic       ok;
  wire        scl_h, sda_h, sda_line, sda_o, sda_oe;
  wire  [3:0] det_start, cls_start, power_enable, off_clear, cool_cancel, manual_power;
  int         err_total = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         n_det = 0;
  int         n_cls = 0;
  int         k, m;
  // Rows cover every mode code, the read-only readback and an unmapped command.
  psecm_row_t rows [7] = '{'{8'h12, 8'h55, 8'h55}, '{8'h12, 8'haa, 8'haa},
    '{8'h12, 8'hff, 8'hff}, '{8'h12, 8'he4, 8'he4}, '{8'h11, 8'hff, 8'h54},
    '{8'h3c, 8'h5a, 8'h00}, '{8'h12, 8'h00, 8'h00}};
  always #12.5 mclk = ~mclk;
  assign sda_line = sda_h & (sda_oe ? sda_o : 1'b1);
  psecm_i2c_host host_u (.mclk(mclk), .sda_line(sda_line), .scl_o(scl_h), .sda_o(sda_h));
  psecm_top dut_u (
    .mclk(mclk), .rst_b(rst_b), .scl_i(scl_h), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_strap_pin(4'ha), .group_pin(1'b1), .config_b(cfg_b),
    .det_done(det_done), .det_valid(valid), .cls_done(cls_done), .pg_in(power_enable),
    .alloc_ok(alloc), .cooldown(cool), .trip_off(trip), .det_start(det_start),
    .cls_start(cls_start), .power_enable(power_enable), .off_clear(off_clear),
    .cool_cancel(cool_cancel), .manual_power(manual_power));
  // The measurement engine answers every start on the following cycle.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    det_done <= #2 det_start;
    cls_done <= #2 cls_start;
    n_det <= n_det + int'(det_start[0]);
    n_cls <= n_cls + int'(cls_start[0]);
    oc_seen <= oc_seen | off_clear;
    cc_seen <= cc_seen | cool_cancel;
    if (cycles == 90000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    host_u.wr(dev, c, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [7:0] exp);
    host_u.rd(dev, c, q, ok);
    chk({7'h0, ok}, 8'h01);
    chk(q, exp);
  endtask
  initial begin
    tick(5);
    rst_b = 1'b1;
    tick(5);
    chk({power_enable, det_start}, 8'h00);
    rchk(8'h12, 8'h00);
    foreach (rows[i]) begin
      wreg(rows[i].cmd, rows[i].wd);
      rchk(rows[i].cmd, rows[i].ex);
    end
    chk({oc_seen, cc_seen}, 8'hf4);
    host_u.wr(7'h36, 8'h12, 8'h55, ok);
    chk({7'h0, ok}, 8'h00);
    host_u.rd(7'h7f, 8'h12, q, ok);
    chk(q, 8'h00);
    cfg_b = 1'b1;
    dev = 7'h34;
    rchk(8'h11, 8'h50);
    cfg_b = 1'b0;
    dev = 7'h35;
    wreg(8'h12, 8'h05);
    k = n_det;
    m = n_cls;
    wreg(8'h14, 8'h11);
    rchk(8'h14, 8'h00);
    chk(8'(n_det - k), 8'h01);
    chk(8'(n_cls - m), 8'h01);
    wreg(8'h19, 8'h03);
    chk({power_enable, manual_power}, 8'h33);
    oc_seen = 4'h0;
    wreg(8'h12, 8'h04);
    // clearing settles before the host looks
    tick(4);
    chk({oc_seen, power_enable}, 8'h12);
    rchk(8'h10, 8'h22);
    rchk(8'h02, 8'h11);
    rchk(8'h02, 8'h00);
    k = n_det;
    wreg(8'h14, 8'h11);
    wreg(8'h19, 8'h01);
    chk({3'h0, power_enable[0], 4'(n_det - k)}, 8'h00);
    wreg(8'h12, 8'h02);
    wreg(8'h14, 8'h11);
    k = n_det;
    m = n_cls;
    tick(50);
    chk({6'h0, n_det - k > 2, n_cls != m}, 8'h02);
    valid = 4'hf;
    tick(50);
    chk({7'h0, n_cls - m > 2}, 8'h01);
    wreg(8'h14, 8'h01);
    m = n_cls;
    tick(50);
    chk(8'(n_cls - m), 8'h00);
    cool = 4'h1;
    cc_seen = 4'h0;
    wreg(8'h12, 8'h01);
    chk({4'h0, cc_seen}, 8'h01);
    cool = 4'h0;
    alloc = 4'hf;
    wreg(8'h12, 8'h03);
    wreg(8'h14, 8'h11);
    tick(20);
    chk({7'h0, power_enable[0]}, 8'h01);
    trip = 4'h1;
    tick(2);
    trip = 4'h0;
    chk({7'h0, power_enable[0]}, 8'h00);
    rchk(8'h02, 8'h33);
    wreg(8'h12, 8'h00);
    chk({7'h0, power_enable[0]}, 8'h00);
    end_of_test();
  end
endmodule
